// file: anp_pkg.sv
// Purpose: Constants and types for the auto-negotiation ability page register bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes:   Register index times four gives the byte address
package anp_pkg;

   // Register indices (byte address = index * 4)
   localparam logic [5:0] ANP_IDX_ADVERT   = 6'h04;
   localparam logic [5:0] ANP_IDX_PARTNER  = 6'h05;
   localparam logic [5:0] ANP_IDX_EXPAN    = 6'h06;
   localparam logic [5:0] ANP_IDX_TX_NP    = 6'h07;
   localparam logic [5:0] ANP_IDX_RX_NP    = 6'h08;
   localparam logic [5:0] ANP_IDX_RXERR    = 6'h15;
   localparam int         ANP_ADDR_LSB     = 2;

   // Advertisement fields
   localparam int ANP_ADV_PAUSE   = 10;
   localparam int ANP_ADV_T4      = 9;
   localparam int ANP_ADV_TX_FD   = 8;
   localparam int ANP_ADV_TX      = 7;
   localparam int ANP_ADV_10_FD   = 6;
   localparam int ANP_ADV_10      = 5;
   localparam logic [4:0] ANP_SEL_8023 = 5'h01;

   // Expansion fields
   localparam int ANP_EXP_PD_FAULT = 4;
   localparam int ANP_EXP_LP_NP    = 3;
   localparam int ANP_EXP_LOC_NP   = 2;
   localparam int ANP_EXP_PAGE_RX  = 1;
   localparam int ANP_EXP_LP_AN    = 0;

   // Transmit next-page fields
   localparam int ANP_NP_NEXT   = 15;
   localparam int ANP_NP_MSG    = 13;
   localparam int ANP_NP_ACK2   = 12;
   localparam int ANP_NP_TOGGLE = 11;
   localparam logic [10:0] ANP_NP_MSG_RST = 11'h001;

   localparam logic [15:0] ANP_ZERO16 = 16'h0000;
   localparam logic [15:0] ANP_ONE16  = 16'h0001;
   localparam logic [15:0] ANP_TALLY_MAX  = 16'hFFFF;
   localparam logic [2:0]  ANP_STRAP_WAIT = 3'h4;

   // AHB encodings
   localparam logic [1:0] ANP_HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] ANP_HTRANS_SEQ    = 2'b11;

   // Partner pause capability decode
   typedef enum logic [1:0] {
      ANP_PAUSE_NONE,
      ANP_PAUSE_ASYM,
      ANP_PAUSE_SYM,
      ANP_PAUSE_BOTH
   } anp_pause_e;

   // Events from the negotiation engine
   typedef struct packed {
      logic        page_valid;   // One-cycle: a link code word received
      logic [15:0] page_word;    // Received word
      logic        page_is_base; // 1 = base page, 0 = next page
      logic        lp_an_able;   // Partner is auto-negotiation capable
      logic        pd_fault;     // Parallel detection fault level
      logic        tx_word_sent; // One-cycle: a local link code word was sent
   } anp_neg_s;

   // AHB data-phase capture
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [5:0] idx;
   } anp_aphase_s;

endpackage

// file: anp_regs.sv
// Purpose: Auto-negotiation ability pages and receive-error tally, AHB-Lite slave
// Assumes: Straps and rx_er come from pins; negotiation events from same-clock logic
// Notes:   Writes zero wait, reads one wait state; unmapped words read zero
//
// Summary of operation
// R1: Writable pause advertisement bit, resets zero
// R2: 100 full duplex reset from both straps
// R3: 100 advert from speed strap; T4 zero
// R4: 10 full from duplex strap; 10 half one
// R5: Writable selector field resets to 802.3
// R6: Partner acknowledge set on received word
// R7: Report partner remote fault, default zero
// R8: Decode partner pause bits to four modes
// R9: Mirror partner technology and selector bits
// R10: Latch high parallel detection fault flag
// R11: Report partner next-page capability bit
// R12: Local next-page capability always reads one
// R13: Latch high page received flag
// R14: Report partner auto-negotiation capability bit
// R15: Next-page bit writable, resets zero
// R16: Message page bit writable, resets one
// R17: Comply acknowledge bit writable, resets zero
// R18: Toggle bit tracks previous sent word
// R19: Writable 11-bit message field resets one
// R20: Capture partner next page fields
// R21: Partner toggle bit reported as received
// R22: Count receive errors per packet, sixteen bits
// R23: Read clears latched flags unless still active
`timescale 1ns/100ps
`default_nettype none

module anp_regs
   import anp_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            sys_rst,
   input  wire logic            speed_select_strap,
   input  wire logic            duplex_strap,
   input  wire logic            rx_er,
   input  wire logic            rx_dv,
   input  wire anp_pkg::anp_neg_s neg,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic            hready,
   input  wire logic [31:0]     hwdata,
   output logic [31:0]          hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic                 tx_toggle,
   output anp_pkg::anp_pause_e  partner_pause
);
   import anp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change counts when stages two and three agree
   logic [2:0] spd_s_q, dup_s_q, er_s_q, dv_s_q;
   logic       spd_q, dup_q, er_q, dv_q;
   logic       strap_done_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         spd_s_q <= 3'h0;
         dup_s_q <= 3'h0;
         er_s_q  <= 3'h0;
         dv_s_q  <= 3'h0;
         spd_q   <= 1'b0;
         dup_q   <= 1'b0;
         er_q    <= 1'b0;
         dv_q    <= 1'b0;
      end else begin
         spd_s_q <= {spd_s_q[1:0], speed_select_strap};
         dup_s_q <= {dup_s_q[1:0], duplex_strap};
         er_s_q  <= {er_s_q[1:0], rx_er};
         dv_s_q  <= {dv_s_q[1:0], rx_dv};
         if (spd_s_q[1] == spd_s_q[2]) spd_q <= spd_s_q[2];
         if (dup_s_q[1] == dup_s_q[2]) dup_q <= dup_s_q[2];
         if (er_s_q[1] == er_s_q[2])   er_q  <= er_s_q[2];
         if (dv_s_q[1] == dv_s_q[2])   dv_q  <= dv_s_q[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address and data phase
   anp_aphase_s ap_q;
   logic        rd_wait_q;
   wire         ap_take = hsel & hready & htrans[1];
   wire  [5:0]  ap_idx  = haddr[ANP_ADDR_LSB +: 6];
   wire         wr_en   = ap_q.valid & ap_q.write;
   wire         rd_en   = ap_q.valid & ~ap_q.write;
   wire         wr_adv  = wr_en & (ap_q.idx == ANP_IDX_ADVERT);
   wire         wr_np   = wr_en & (ap_q.idx == ANP_IDX_TX_NP);
   // Clear only at the capture edge, so a later event is not lost
   wire         rd_exp  = rd_wait_q & (ap_q.idx == ANP_IDX_EXPAN);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ap_q <= '0;
      end else if (hready) begin
         ap_q.valid <= ap_take;
         ap_q.write <= hwrite;
         ap_q.idx   <= ap_idx;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local advertisement
   logic       adv_pause_q, adv_txfd_q, adv_tx_q, adv_10fd_q, adv_10_q;
   logic [4:0] adv_sel_q;

   // Straps are caught one cycle after the synchronisers settle
   logic [2:0] strap_cnt_q;
   wire        strap_load = (strap_cnt_q == ANP_STRAP_WAIT) & ~strap_done_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         strap_cnt_q  <= 3'h0;
         strap_done_q <= 1'b0;
      end else begin
         if (strap_cnt_q != ANP_STRAP_WAIT) strap_cnt_q <= strap_cnt_q + 3'h1;
         if (strap_load)          strap_done_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         adv_pause_q <= 1'b0;                      // see R1
         adv_txfd_q  <= 1'b0;
         adv_tx_q    <= 1'b0;
         adv_10fd_q  <= 1'b0;
         adv_10_q    <= 1'b1;                      // see R4
         adv_sel_q   <= ANP_SEL_8023;              // see R5
      end else if (strap_load) begin
         adv_txfd_q <= spd_q & dup_q;              // see R2
         adv_tx_q   <= spd_q;                      // see R3
         adv_10fd_q <= dup_q;                      // see R4
      end else if (wr_adv) begin
         adv_pause_q <= hwdata[ANP_ADV_PAUSE];     // see R1
         adv_txfd_q  <= hwdata[ANP_ADV_TX_FD];     // see R2
         adv_tx_q    <= hwdata[ANP_ADV_TX];        // see R3
         adv_10fd_q  <= hwdata[ANP_ADV_10_FD];     // see R4
         adv_10_q    <= hwdata[ANP_ADV_10];        // see R4
         adv_sel_q   <= hwdata[4:0];               // see R5
      end
   end

   logic [15:0] adv_word;
   always_comb begin
      adv_word                = ANP_ZERO16;
      adv_word[ANP_ADV_PAUSE] = adv_pause_q;
      adv_word[ANP_ADV_T4]    = 1'b0;              // see R3
      adv_word[ANP_ADV_TX_FD] = adv_txfd_q;
      adv_word[ANP_ADV_TX]    = adv_tx_q;
      adv_word[ANP_ADV_10_FD] = adv_10fd_q;
      adv_word[ANP_ADV_10]    = adv_10_q;
      adv_word[4:0]           = adv_sel_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Partner base page and next page capture
   logic [15:0] pba_q, rxnp_q;
   wire         base_rx = neg.page_valid & neg.page_is_base;
   wire         np_rx   = neg.page_valid & ~neg.page_is_base;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pba_q  <= ANP_ZERO16;
         rxnp_q <= ANP_ZERO16;
      end else begin
         if (base_rx) pba_q  <= neg.page_word;     // see R6 R7 R9
         if (np_rx)   rxnp_q <= neg.page_word;     // see R20 R21
      end
   end

   // Reserved bit 12 of the base page is never shown
   wire [15:0] pba_word = {pba_q[15:13], 1'b0, pba_q[11:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Expansion flags
   logic pd_fault_q, page_rx_q, lp_an_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pd_fault_q <= 1'b0;
         page_rx_q  <= 1'b0;
         lp_an_q    <= 1'b0;
      end else begin
         // Event wins over a read in the same cycle
         if (neg.pd_fault)  pd_fault_q <= 1'b1;    // see R10 R23
         else if (rd_exp)   pd_fault_q <= 1'b0;
         if (neg.page_valid) page_rx_q <= 1'b1;    // see R13 R23
         else if (rd_exp)    page_rx_q <= 1'b0;
         lp_an_q <= neg.lp_an_able;                // see R14
      end
   end

   logic [15:0] exp_word;
   always_comb begin
      exp_word                   = ANP_ZERO16;
      exp_word[ANP_EXP_PD_FAULT] = pd_fault_q;
      exp_word[ANP_EXP_LP_NP]    = pba_q[ANP_NP_NEXT];   // see R11
      exp_word[ANP_EXP_LOC_NP]   = 1'b1;                  // see R12
      exp_word[ANP_EXP_PAGE_RX]  = page_rx_q;
      exp_word[ANP_EXP_LP_AN]    = lp_an_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Local transmit next page
   logic        np_next_q, np_msg_q, np_ack2_q, np_tog_q;
   logic [10:0] np_field_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         np_next_q  <= 1'b0;                       // see R15
         np_msg_q   <= 1'b1;                       // see R16
         np_ack2_q  <= 1'b0;                       // see R17
         np_field_q <= ANP_NP_MSG_RST;             // see R19
      end else if (wr_np) begin
         np_next_q  <= hwdata[ANP_NP_NEXT];        // see R15
         np_msg_q   <= hwdata[ANP_NP_MSG];         // see R16
         np_ack2_q  <= hwdata[ANP_NP_ACK2];        // see R17
         np_field_q <= hwdata[10:0];               // see R19
      end
   end

   // Toggle flips after each sent word so it holds the inverse of the last word's value
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         np_tog_q <= 1'b0;
      end else if (neg.tx_word_sent) begin
         np_tog_q <= ~np_tog_q;                    // see R18
      end
   end

   wire [15:0] txnp_word = {np_next_q, 1'b0, np_msg_q, np_ack2_q, np_tog_q, np_field_q};

   ////////////////////////////////////////////////////////////////////////////
   // Receive error tally: one count per packet that saw an error
   logic [15:0] rxerr_q;
   logic        pkt_err_q, dv_d1_q;
   wire         pkt_end = dv_d1_q & ~dv_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rxerr_q   <= ANP_ZERO16;
         pkt_err_q <= 1'b0;
         dv_d1_q   <= 1'b0;
      end else begin
         dv_d1_q <= dv_q;
         if (pkt_end) begin
            pkt_err_q <= 1'b0;
            if ((pkt_err_q | er_q) && rxerr_q != ANP_TALLY_MAX)
               rxerr_q <= rxerr_q + ANP_ONE16;     // see R22
         end else if (dv_q & er_q) begin
            pkt_err_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and outputs
   logic [15:0] rd_word;
   always_comb begin
      unique case (ap_q.idx)
         ANP_IDX_ADVERT:  rd_word = adv_word;
         ANP_IDX_PARTNER: rd_word = pba_word;
         ANP_IDX_EXPAN:   rd_word = exp_word;
         ANP_IDX_TX_NP:   rd_word = txnp_word;
         ANP_IDX_RX_NP:   rd_word = {rxnp_q[15:12], rxnp_q[11], rxnp_q[10:0]};
         ANP_IDX_RXERR:   rd_word = rxerr_q;
         default:         rd_word = ANP_ZERO16;
      endcase
   end

   // Data is registered in the data phase, so reads carry one wait state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hrdata        <= '0;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         rd_wait_q     <= 1'b0;
         tx_toggle     <= 1'b0;
         partner_pause <= ANP_PAUSE_NONE;
      end else begin
         rd_wait_q <= ap_take & ~hwrite;
         hreadyout <= ~(ap_take & ~hwrite);
         if (rd_wait_q) hrdata <= {ANP_ZERO16, rd_word};
         tx_toggle <= np_tog_q;
         unique case (pba_q[11:10])                // see R8
            2'b00: partner_pause <= ANP_PAUSE_NONE;
            2'b10: partner_pause <= ANP_PAUSE_ASYM;
            2'b01: partner_pause <= ANP_PAUSE_SYM;
            2'b11: partner_pause <= ANP_PAUSE_BOTH;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_page_in;
      neg.page_valid;
   endsequence

   AST_ADV_PAUSE_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // see R1
      wr_adv && !strap_load |=> adv_word[ANP_ADV_PAUSE] == $past(hwdata[ANP_ADV_PAUSE]))
      else $error("pause advert not written");
   AST_STRAP_TXFD: assert property (@(posedge clock) disable iff (sys_rst) // see R2
      strap_load |=> adv_txfd_q == $past(spd_q & dup_q))
      else $error("100 full duplex strap not loaded");
   AST_T4_ZERO: assert property (@(posedge clock) disable iff (sys_rst) // see R3
      rd_en && ap_q.idx == ANP_IDX_ADVERT |-> !rd_word[ANP_ADV_T4])
      else $error("T4 advert not zero");
   AST_PAGE_RX_LATCH: assert property (@(posedge clock) disable iff (sys_rst) // see R13
      s_page_in |=> page_rx_q)
      else $error("page received flag not set");
   AST_PD_FAULT_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // see R23
      pd_fault_q && !rd_exp |=> pd_fault_q)
      else $error("fault flag cleared without read");
   AST_PAGE_RX_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // see R23
      page_rx_q && !rd_exp |=> page_rx_q)
      else $error("page flag cleared without read");
   AST_LOC_NP: assert property (@(posedge clock) disable iff (sys_rst) // see R12
      exp_word[ANP_EXP_LOC_NP])
      else $error("local next page bit low");
   AST_TOGGLE: assert property (@(posedge clock) disable iff (sys_rst) // see R18
      neg.tx_word_sent |=> np_tog_q != $past(np_tog_q))
      else $error("toggle did not flip");
   AST_ACK_CAPTURE: assert property (@(posedge clock) disable iff (sys_rst) // see R6
      base_rx && neg.page_word[14] |=> pba_word[14] ##1 pba_word[14] || $past(base_rx))
      else $error("partner ack not captured");
   AST_RXERR_COUNT: assert property (@(posedge clock) disable iff (sys_rst) // see R22
      pkt_end && (pkt_err_q || er_q) && rxerr_q != ANP_TALLY_MAX
      |=> rxerr_q == $past(rxerr_q) + ANP_ONE16)
      else $error("receive error not counted");
   AST_NP_CAPTURE: assert property (@(posedge clock) disable iff (sys_rst) // see R20
      np_rx |=> rxnp_q == $past(neg.page_word))
      else $error("next page not captured");

endmodule

`default_nettype wire

// file: anp_link_partner.sv
// Purpose: Far-side model: negotiation engine events and receive pins
// Assumes: Every task is entered just after a rising clock edge
// Notes:   Idle word lines show the inverse of the last page
`timescale 1ns/100ps
`default_nettype none

module anp_link_partner
   import anp_pkg::*;
(
   input  wire logic             clock,
   output var anp_pkg::anp_neg_s neg,
   output var logic              rx_dv,
   output var logic              rx_er
);
   import anp_pkg::*;

   initial begin
      neg = '0;
      rx_dv = 1'b0;
      rx_er = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle page strobe; stale word must not look valid
   task automatic send_page(input logic [15:0] w, input logic base);
      neg.page_valid <= 1'b1;
      neg.page_word <= w;
      neg.page_is_base <= base;
      @(posedge clock);
      neg.page_valid <= 1'b0;
      neg.page_word <= ~w;
   endtask

   task automatic set_flags(input logic an, input logic fault);
      neg.lp_an_able <= an;
      neg.pd_fault <= fault;
   endtask

   task automatic word_sent();
      neg.tx_word_sent <= 1'b1;
      @(posedge clock);
      neg.tx_word_sent <= 1'b0;
   endtask

   // Error pulse in the third and fourth cycles lasts two cycles, so the pin filter lets it through; a lone last-cycle pulse is filtered
   task automatic send_packet(input int len, input logic err);
      rx_dv <= 1'b1;
      for (int i = 0; i < len; i++) begin
         rx_er <= err && i[1];
         @(posedge clock);
      end
      rx_er <= 1'b0;
      rx_dv <= 1'b0;
   endtask
endmodule

`default_nettype wire

// file: autoneg_ability_pages_tb_top.sv
// Purpose: Self-checking bench for the ability page register bank
// Assumes: Single AHB-Lite master, hready fed from hreadyout
// Notes:   Random data from a fixed-seed xorshift
`timescale 1ns/100ps
`default_nettype none

module autoneg_ability_pages_tb_top
   import anp_pkg::*;
;
   logic        clock;
   logic        sys_rst;
   logic        speed_select_strap;
   logic        duplex_strap;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        tx_toggle;
   anp_pause_e  partner_pause;
   anp_neg_s    neg;
   logic        rx_dv;
   logic        rx_er;
   logic [31:0] rng;
   int          n_fail;
   int          n_checks;

   anp_regs dut (
      .clock(clock), .sys_rst(sys_rst),
      .speed_select_strap(speed_select_strap), .duplex_strap(duplex_strap),
      .rx_er(rx_er), .rx_dv(rx_dv), .neg(neg),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .tx_toggle(tx_toggle), .partner_pause(partner_pause)
   );

   anp_link_partner lp (.clock(clock), .neg(neg), .rx_dv(rx_dv), .rx_er(rx_er));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [15:0] advert_exp(input logic spd, input logic dup);
      return {6'h00, 1'b0, spd & dup, spd, dup, 1'b1, ANP_SEL_8023};
   endfunction

   // Bit 10 symmetric, bit 11 asymmetric
   function automatic anp_pause_e pause_exp(input logic [1:0] b);
      case (b)
         2'b00: return ANP_PAUSE_NONE;
         2'b01: return ANP_PAUSE_SYM;
         2'b10: return ANP_PAUSE_ASYM;
         default: return ANP_PAUSE_BOTH;
      endcase
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Caller sits just after an edge; the bus idles during each data phase, so transfers do not overlap
   task automatic ahb_addr(input logic [5:0] idx, input logic wr);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, idx, 2'b00};
      htrans <= ANP_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'b00;
   endtask

   task automatic ahb_write(input logic [5:0] idx, input logic [31:0] d);
      ahb_addr(idx, 1'b1);
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [15:0] exp);
      ahb_addr(idx, 1'b0);
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      check(hrdata, {16'h0000, exp});
   endtask

   // Straps held well past the synchroniser and load point
   task automatic do_reset(input logic spd, input logic dup);
      speed_select_strap <= spd;
      duplex_strap <= dup;
      sys_rst <= 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (12) @(posedge clock);
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      finish_test();
   end

   initial begin
      logic [15:0] w;
      logic [15:0] cnt;
      logic        np;
      logic        tog;
      logic        err;
      rng = 32'h0000_3c09;
      n_fail = 0;
      n_checks = 0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         do_reset(i[1], i[0]);
         rdc(ANP_IDX_ADVERT, advert_exp(i[1], i[0]));
      end
      rdc(ANP_IDX_PARTNER, 16'h0000);
      rdc(ANP_IDX_EXPAN, 16'h0004);
      rdc(ANP_IDX_TX_NP, 16'h2001);
      rdc(ANP_IDX_RX_NP, 16'h0000);
      ahb_write(ANP_IDX_PARTNER, 32'hffff_ffff);
      ahb_write(ANP_IDX_RXERR, 32'hffff_ffff);
      ahb_write(6'h10, 32'hffff_ffff);
      rdc(ANP_IDX_PARTNER, 16'h0000);
      rdc(ANP_IDX_RXERR, 16'h0000);
      rdc(6'h10, 16'h0000);
      tog = 1'b0;
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         ahb_write(ANP_IDX_ADVERT, rng);
         rdc(ANP_IDX_ADVERT, rng[15:0] & 16'h05ff);
         if (rng[4]) begin
            lp.word_sent();
            tog = ~tog;
            repeat (2) @(posedge clock);
            check({31'h0, tx_toggle}, {31'h0, tog});
         end
         ahb_write(ANP_IDX_TX_NP, ~rng);
         rdc(ANP_IDX_TX_NP, (~rng[15:0] & 16'hb7ff) | {4'h0, tog, 11'h000});
      end
      for (int p = 0; p < 4; p++) begin
         rng = xs(rng);
         w = {rng[15], 1'b1, rng[13:12], p[1:0], rng[9:0]};
         lp.set_flags(p[0], 1'b0);
         lp.send_page(w, 1'b1);
         repeat (2) @(posedge clock);
         check({30'h0, partner_pause}, {30'h0, pause_exp(p[1:0])});
         rdc(ANP_IDX_PARTNER, w & 16'hefff);
         rdc(ANP_IDX_EXPAN, {11'h000, 1'b0, w[15], 2'b11, p[0]});
         rdc(ANP_IDX_EXPAN, {11'h000, 1'b0, w[15], 2'b10, p[0]});
      end
      np = w[15];
      rng = xs(rng);
      w = rng[15:0];
      lp.send_page(w, 1'b0);
      repeat (2) @(posedge clock);
      rdc(ANP_IDX_RX_NP, w);
      rdc(ANP_IDX_EXPAN, {11'h000, 1'b0, np, 2'b11, 1'b1});
      lp.set_flags(1'b1, 1'b1);
      repeat (3) @(posedge clock);
      rdc(ANP_IDX_EXPAN, {11'h000, 1'b1, np, 2'b10, 1'b1});
      rdc(ANP_IDX_EXPAN, {11'h000, 1'b1, np, 2'b10, 1'b1});
      lp.set_flags(1'b1, 1'b0);
      @(posedge clock);
      rdc(ANP_IDX_EXPAN, {11'h000, 1'b1, np, 2'b10, 1'b1});
      rdc(ANP_IDX_EXPAN, {11'h000, 1'b0, np, 2'b10, 1'b1});
      cnt = 16'h0000;
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         err = rng[0] | (k == 0);
         lp.send_packet(4 + rng[3:1], err);
         cnt = cnt + {15'h0000, err};
         repeat (4) @(posedge clock);
      end
      repeat (6) @(posedge clock);
      rdc(ANP_IDX_RXERR, cnt);
      finish_test();
   end
endmodule

`default_nettype wire
